/* File: rtl/clk_div.sv */
// free-running divider, toggles once every half ratio
`include "mfpin_cfg.svh"
module clk_div #(
    parameter int RATIO = `CLKDIV_RATIO
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      div_o
);
    localparam int CW = $clog2(RATIO / 2);
    localparam logic [CW-1:0] LAST = CW'(RATIO / 2 - 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          tog_q;
    logic          tog_d;
    always_comb begin
        cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        tog_d = (cnt_q == LAST) ? ~tog_q : tog_q;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tog_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tog_q <= tog_d;
        end
    end
    assign div_o = tog_q;
endmodule : clk_div

/* File: rtl/mfpin_cfg.svh */
// register offsets, codes and field positions for the multifunction pin block
`ifndef MFPIN_CFG_SVH
`define MFPIN_CFG_SVH
`define ADDR_CFG0       12'h000
`define ADDR_CFG1       12'h004
`define ADDR_STAT0      12'h008
`define ADDR_STAT1      12'h00C
`define ADDR_STAT2      12'h010
`define ADDR_IRQ_STAT   12'h014
`define ADDR_IRQ_MASK   12'h018
`define ADDR_PIN_STATE  12'h01C
`define DIR_BIT         7
`define CFG_RESET       8'h00
`define CLKDIV_RATIO    32
`define OUT_LOW         8'h80
`define OUT_HIGH        8'h81
`define OUT_CLKDIV      8'h82
`define OUT_WDOG        8'h83
`define OUT_EE_UP       8'h84
`define OUT_EE_DN       8'h85
`define OUT_EE_FAULT    8'h86
`define OUT_MUL_LOCK    8'h87
`define OUT_MUL_STABLE  8'h88
`define OUT_OUT_LOCK    8'h89
`define OUT_AN_CAL      8'h8A
`define OUT_AN_REF      8'h8B
`define OUT_ALL_LOCK    8'h8C
`define OUT_DA_LOCK     8'h8D
`define OUT_FREE_RUN    8'h90
`define OUT_ACTIVE      8'h91
`define OUT_HOLDOVER    8'h92
`define OUT_SWITCH      8'h93
`define OUT_PH_LOCK     8'h94
`define OUT_FR_LOCK     8'h95
`define OUT_SLEW        8'h96
`define OUT_CLAMP       8'h97
`define OUT_HIST_AVAIL  8'h98
`define OUT_HIST_UPD    8'h99
`define OUT_DIST_SYNC   8'hD0
`define OUT_SOFT_CFG    8'hD1
`define IN_CLR_WDOG     8'h03
`define IN_CLR_IRQ      8'h04
`define IN_HIST_RST     8'h05
`define IN_PH_RST       8'h12
`define IN_PH_INC       8'h13
`define IN_PH_DEC       8'h14
`define IN_MON_A        8'h20
`define IN_MON_B        8'h21
`define IN_VTO_A        8'h30
`define IN_VTO_B        8'h31
`define IN_EN_FIRST_CLOCK_OUTPUT      8'h40
`define IN_EN_SECOND_CLOCK_OUTPUT      8'h41
`define IN_EN_BOTH      8'h46
`define IN_DIST_SYNC    8'h47
`endif

/* File: rtl/mfpin_pkg.sv */
// types shared by the multifunction pin block
package mfpin_pkg;
    typedef struct packed {
        logic clr_watchdog;
        logic clr_all_irq;
        logic history_reset;
        logic phase_reset;
        logic phase_inc;
        logic phase_dec;
        logic mon_override_a;
        logic mon_override_b;
        logic force_vto_a;
        logic force_vto_b;
        logic first_clock_output_en;
        logic second_clock_output_en;
        logic dist_sync;
    } ctrl_t;
    typedef struct packed {
        logic [2:0] eeprom;
        logic [6:0] loops;
        logic [6:0] digital_loop;
        logic       freq_clamped;
        logic       history_avail;
        logic       history_updated;
        logic       dist_sync_pulse;
        logic       soft_cfg_busy;
        logic       watchdog;
    } status_t;
endpackage : mfpin_pkg

/* File: rtl/mfpin_top.sv */
// multifunction pin function select with apb registers and interrupt
// Contract
// - top config bit selects output or input
// - code 0x82 drives clock divided by 32
// - codes 0x84-0x86 mirror eeprom flags
// - codes 0x87-0x8B mirror loop status bits
// - 0x8C all locks, 0x8D two locks
// - codes 0x90-0x96 mirror digital loop state
// - 0x97 clamp, 0x98/0x99 history flags
// - distribution sync pulse and soft config busy
// - inputs clear watchdog, irqs, history
// - inputs reset, increment, decrement phase offset
// - inputs override reference monitors a, b
// - inputs force validation timeouts a, b
// - inputs enable first, second, both outputs
// - input triggers distribution output sync
`include "mfpin_cfg.svh"
module mfpin_top
    import mfpin_pkg::*;
#(
    parameter int NPINS = 2
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire status_t           status,
    input  wire logic [NPINS-1:0]  pin_i,
    output logic      [NPINS-1:0]  pin_o,
    output logic      [NPINS-1:0]  pin_oe,
    output ctrl_t                  ctrl,
    output logic                   irq
);
    logic [7:0]       cfg_q   [NPINS];
    logic [7:0]       cfg_d   [NPINS];
    logic [NPINS-1:0] sync_pin;
    logic [NPINS-1:0] out_d;
    logic [NPINS-1:0] out_q;
    logic [NPINS-1:0] oe_d;
    logic [NPINS-1:0] oe_q;
    logic [NPINS-1:0] prev_q;
    logic [NPINS-1:0] prev_d;
    logic [NPINS-1:0] ist_q;
    logic [NPINS-1:0] ist_d;
    logic [NPINS-1:0] imask_q;
    logic [NPINS-1:0] imask_d;
    ctrl_t            ctrl_d;
    ctrl_t            ctrl_q;
    logic [31:0]      rdata_d;
    logic [31:0]      rdata_q;
    logic             slverr_d;
    logic             div_clk;
    logic             wr_en;
    logic             rd_en;

    clk_div #(
        .RATIO (`CLKDIV_RATIO)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .div_o   (div_clk)
    );

    for (genvar g = 0; g < NPINS; g++) begin : g_sync
        pin_sync u_sync (
            .pclk    (pclk),
            .presetn (presetn),
            .pin_i   (pin_i[g]),
            .pin_o   (sync_pin[g])
        );
    end

    // maps an output code to its status source; reserved codes give low
    function automatic logic out_sel(input logic [7:0] code, input status_t s,
                                     input logic dv);
        logic r;
        r = 1'b0;
        case (code)
            `OUT_LOW:        r = 1'b0;
            `OUT_HIGH:       r = 1'b1;
            `OUT_CLKDIV:     r = dv;
            `OUT_WDOG:       r = s.watchdog;
            `OUT_EE_UP:      r = s.eeprom[0];
            `OUT_EE_DN:      r = s.eeprom[1];
            `OUT_EE_FAULT:   r = s.eeprom[2];
            `OUT_MUL_LOCK:   r = s.loops[0];
            `OUT_MUL_STABLE: r = s.loops[1];
            `OUT_OUT_LOCK:   r = s.loops[2];
            `OUT_AN_CAL:     r = s.loops[3];
            `OUT_AN_REF:     r = s.loops[4];
            `OUT_ALL_LOCK:   r = s.loops[5];
            `OUT_DA_LOCK:    r = s.loops[6];
            `OUT_FREE_RUN:   r = s.digital_loop[0];
            `OUT_ACTIVE:     r = s.digital_loop[1];
            `OUT_HOLDOVER:   r = s.digital_loop[2];
            `OUT_SWITCH:     r = s.digital_loop[3];
            `OUT_PH_LOCK:    r = s.digital_loop[4];
            `OUT_FR_LOCK:    r = s.digital_loop[5];
            `OUT_SLEW:       r = s.digital_loop[6];
            `OUT_CLAMP:      r = s.freq_clamped;
            `OUT_HIST_AVAIL: r = s.history_avail;
            `OUT_HIST_UPD:   r = s.history_updated;
            `OUT_DIST_SYNC:  r = s.dist_sync_pulse;
            `OUT_SOFT_CFG:   r = s.soft_cfg_busy;
            default:         r = 1'b0;
        endcase
        return r;
    endfunction : out_sel

    // pin outputs and direction
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (cfg_q[i][`DIR_BIT]) begin
                oe_d[i]  = 1'b1;
                out_d[i] = out_sel(cfg_q[i], status, div_clk);
            end else begin
                oe_d[i]  = 1'b0;
                out_d[i] = 1'b0;
            end
        end
    end

    // input-mode control: pin level acts as the equivalent control bit
    always_comb begin
        ctrl_d = '0;
        for (int i = 0; i < NPINS; i++) begin
            if (!cfg_q[i][`DIR_BIT] && sync_pin[i]) begin
                case (cfg_q[i])
                    `IN_CLR_WDOG:  ctrl_d.clr_watchdog = 1'b1;
                    `IN_CLR_IRQ:   ctrl_d.clr_all_irq = 1'b1;
                    `IN_HIST_RST:  ctrl_d.history_reset = 1'b1;
                    `IN_PH_RST:    ctrl_d.phase_reset = 1'b1;
                    `IN_PH_INC:    ctrl_d.phase_inc = 1'b1;
                    `IN_PH_DEC:    ctrl_d.phase_dec = 1'b1;
                    `IN_MON_A:     ctrl_d.mon_override_a = 1'b1;
                    `IN_MON_B:     ctrl_d.mon_override_b = 1'b1;
                    `IN_VTO_A:     ctrl_d.force_vto_a = 1'b1;
                    `IN_VTO_B:     ctrl_d.force_vto_b = 1'b1;
                    `IN_EN_FIRST_CLOCK_OUTPUT:   ctrl_d.first_clock_output_en = 1'b1;
                    `IN_EN_SECOND_CLOCK_OUTPUT:   ctrl_d.second_clock_output_en = 1'b1;
                    `IN_EN_BOTH: begin
                        ctrl_d.first_clock_output_en  = 1'b1;
                        ctrl_d.second_clock_output_en = 1'b1;
                    end
                    `IN_DIST_SYNC: ctrl_d.dist_sync = 1'b1;
                    default:       ctrl_d = ctrl_d;
                endcase
            end
        end
    end

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    // register writes, pin-change events and sticky status
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            cfg_d[i] = cfg_q[i];
        end
        imask_d = imask_q;
        ist_d   = ist_q;
        prev_d  = sync_pin;
        if (wr_en) begin
            case (paddr)
                `ADDR_CFG0:     cfg_d[0] = pwdata[7:0];
                `ADDR_CFG1:     cfg_d[NPINS-1] = pwdata[7:0];
                `ADDR_IRQ_MASK: imask_d = pwdata[NPINS-1:0];
                `ADDR_IRQ_STAT: ist_d = ist_q & ~pwdata[NPINS-1:0];
                default:        ist_d = ist_d;
            endcase
        end
        // set after clear so a same-cycle event is not lost
        for (int i = 0; i < NPINS; i++) begin
            if (!cfg_q[i][`DIR_BIT] && (sync_pin[i] != prev_q[i])) begin
                ist_d[i] = 1'b1;
            end
        end
    end

    // read data is registered in setup so the access phase finishes at once
    always_comb begin
        rdata_d  = rdata_q;
        slverr_d = 1'b0;
        if (rd_en) begin
            rdata_d = '0;
            case (paddr)
                `ADDR_CFG0:      rdata_d[7:0] = cfg_q[0];
                `ADDR_CFG1:      rdata_d[7:0] = cfg_q[NPINS-1];
                `ADDR_STAT0:     rdata_d[2:0] = status.eeprom;
                `ADDR_STAT1:     rdata_d[6:0] = status.loops;
                `ADDR_STAT2:     rdata_d[6:0] = status.digital_loop;
                `ADDR_IRQ_STAT:  rdata_d[NPINS-1:0] = ist_q;
                `ADDR_IRQ_MASK:  rdata_d[NPINS-1:0] = imask_q;
                `ADDR_PIN_STATE: rdata_d[NPINS-1:0] = sync_pin;
                default:         rdata_d = '0;
            endcase
        end
        if (psel && penable) begin
            case (paddr)
                `ADDR_CFG0, `ADDR_CFG1, `ADDR_STAT0, `ADDR_STAT1, `ADDR_STAT2,
                `ADDR_IRQ_STAT, `ADDR_IRQ_MASK, `ADDR_PIN_STATE: slverr_d = 1'b0;
                default: slverr_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NPINS; i++) begin
                cfg_q[i] <= `CFG_RESET;
            end
            out_q   <= '0;
            oe_q    <= '0;
            prev_q  <= '0;
            ist_q   <= '0;
            imask_q <= '0;
            ctrl_q  <= '0;
            rdata_q <= '0;
        end else begin
            cfg_q   <= cfg_d;
            out_q   <= out_d;
            oe_q    <= oe_d;
            prev_q  <= prev_d;
            ist_q   <= ist_d;
            imask_q <= imask_d;
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    assign pin_o   = out_q;
    assign pin_oe  = oe_q;
    assign ctrl    = ctrl_q;
    assign irq     = |(ist_q & imask_q);
    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = slverr_d;
endmodule : mfpin_top

/* File: rtl/pin_sync.sv */
// two-stage synchroniser for an external pin level
module pin_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_i,
    output logic      pin_o
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    always_comb begin
        meta_d = pin_i;
        sync_d = meta_q;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end
    assign pin_o = sync_q;
endmodule : pin_sync

/* File: test/board_model.sv */
// board-side logic driving and sensing the multifunction pins
module board_model #(
    parameter int NPINS = 2
) (
    input  wire logic             pclk,
    input  wire logic [NPINS-1:0] pin_o,
    input  wire logic [NPINS-1:0] pin_oe,
    input  wire logic [NPINS-1:0] drv_en,
    input  wire logic [NPINS-1:0] drv_val,
    output logic      [NPINS-1:0] pin_i
);
    logic [NPINS-1:0] float_q = '0;
    // no pull on the line: a floating pin wanders instead of holding a value
    always @(posedge pclk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (pin_oe[i])
                pin_i[i] = pin_o[i];
            else if (drv_en[i])
                pin_i[i] = drv_val[i];
            else
                pin_i[i] = float_q[i];
        end
    end
endmodule : board_model

/* File: test/pin_monitor.sv */
// bound checker for the multifunction pin block
`include "mfpin_cfg.svh"
module pin_monitor
    import mfpin_pkg::*;
#(
    parameter int NPINS = 2
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire status_t          status,
    input wire logic [NPINS-1:0] pin_i,
    input wire logic [NPINS-1:0] pin_o,
    input wire logic [NPINS-1:0] pin_oe,
    input wire ctrl_t            ctrl
);
    logic [7:0] cfg0_q, cfg0_d, cfg1_q, cfg1_d;
    logic       wr;
    // shadow config, followed from the bus since the internals are hidden
    always_comb begin
        wr     = psel && penable && pready && pwrite;
        cfg0_d = (wr && paddr == `ADDR_CFG0) ? pwdata[7:0] : cfg0_q;
        cfg1_d = (wr && paddr == `ADDR_CFG1) ? pwdata[7:0] : cfg1_q;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {cfg0_q, cfg1_q} <= {`CFG_RESET, `CFG_RESET};
        end else begin
            {cfg0_q, cfg1_q} <= {cfg0_d, cfg1_d};
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_dir_oe: assert property (pin_oe[0] == $past(cfg0_q[7]))
        else $error("pin drive differs from direction bit");
    a_static_high: assert property ($past(cfg0_q) == `OUT_HIGH |-> pin_o[0])
        else $error("static high not driven");
    a_ee_mirror: assert property ($past(cfg0_q) == `OUT_EE_DN |-> pin_o[0] == $past(status.eeprom[1]))
        else $error("eeprom flag not on pin");
    a_loop_mirror: assert property ($past(cfg0_q) == `OUT_AN_CAL |-> pin_o[0] == $past(status.loops[3]))
        else $error("loop flag not on pin");
    a_all_lock: assert property ($past(cfg0_q) == `OUT_ALL_LOCK |-> pin_o[0] == $past(status.loops[5]))
        else $error("lock flag not on pin");
    a_dl_mirror: assert property ($past(cfg0_q) == `OUT_SLEW |-> pin_o[0] == $past(status.digital_loop[6]))
        else $error("loop state not on pin");
    a_hist_flag: assert property ($past(cfg0_q) == `OUT_HIST_UPD |-> pin_o[0] == $past(status.history_updated))
        else $error("history flag not on pin");
    a_soft_cfg: assert property ($past(cfg0_q) == `OUT_SOFT_CFG |-> pin_o[0] == $past(status.soft_cfg_busy))
        else $error("soft config flag not on pin");
    a_rsv_low: assert property ($past(cfg0_q) == 8'h8E |-> pin_oe[0] && !pin_o[0])
        else $error("reserved output not low");
    a_sync_ctrl: assert property ((cfg0_q == `IN_PH_INC && cfg1_q[7])[*4] |-> ctrl.phase_inc == $past(pin_i[0], 3))
        else $error("control not three edges after pin");
    c_clkdiv: cover property ($past(cfg0_q) == `OUT_CLKDIV && $changed(pin_o[0]));
    c_inc: cover property (ctrl.phase_inc);
    c_both: cover property (ctrl.first_clock_output_en && ctrl.second_clock_output_en);
endmodule : pin_monitor

/* File: test/tb.sv */
// self-checking bench for the multifunction pin block
`include "mfpin_cfg.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb import mfpin_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, lfsr = 32'h0000_bff9;
    logic [1:0]  pin_i, pin_o, pin_oe, drv_en = 2'b01, drv_val = '0;
    logic [33:0] exp_q[$];
    logic [7:0]  in_codes[13] = '{8'h03, 8'h04, 8'h05, 8'h12, 8'h13, 8'h14, 8'h20, 8'h21,
                                 8'h30, 8'h31, 8'h40, 8'h41, 8'h47};
    status_t     status = '0;
    ctrl_t       ctrl;
    int          n_mismatch = 0, num_checks = 0, cyc = 0, n;
    logic        w;
    always #4 pclk = ~pclk;
    mfpin_top #(.NPINS(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .status(status), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .ctrl(ctrl), .irq(irq));
    board_model #(.NPINS(2)) u_board (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe),
        .drv_en(drv_en), .drv_val(drv_val), .pin_i(pin_i));
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt
    function automatic logic exp_pin(input logic [7:0] c, input status_t s);
        case (c) inside
            8'h81: return 1'b1;
            8'h83: return s.watchdog;
            [8'h84:8'h86]: return s.eeprom[c - 8'h84];
            [8'h87:8'h8D]: return s.loops[c - 8'h87];
            [8'h90:8'h96]: return s.digital_loop[c - 8'h90];
            8'h97: return s.freq_clamped;
            8'h98: return s.history_avail;
            8'h99: return s.history_updated;
            8'hD0: return s.dist_sync_pulse;
            8'hD1: return s.soft_cfg_busy;
            default: return 1'b0;
        endcase
    endfunction : exp_pin
    function automatic ctrl_t exp_ctrl(input logic [7:0] c);
        ctrl_t r;
        r = '0;
        foreach (in_codes[i]) if (in_codes[i] == c) r[12 - i] = 1'b1;
        if (c == 8'h46) r = ctrl_t'(13'h0006);
        return r;
    endfunction : exp_ctrl
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic e = 1'b0);
        exp_q.push_back({!wr, e, d});
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // reads are judged when they complete, against the oldest note
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (psel && penable && pready) begin
            if (exp_q[0][33]) `CHK("prdata", exp_q[0][31:0], prdata)
            `CHK("pslverr", exp_q[0][32], pslverr)
            exp_q.delete(0);
        end
        // timeout last, so nothing runs after the closing report
        if (cyc == 30000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ADDR_CFG0, 32'h0);
        apb(1'b0, 12'h020, 32'h0, 1'b1);
        apb(1'b1, 12'h024, 32'h0000_ffff, 1'b1);
        for (int c = 8'h80; c <= 8'hD1; c++) begin
            lfsr = nxt(lfsr);
            @(posedge pclk) status <= status_t'(lfsr[22:0]);
            apb(1'b1, `ADDR_CFG0, 32'(c));
            // pins follow the new code one edge after the write lands
            @(posedge pclk);
            @(negedge pclk);
            if (c != 8'h82) `CHK("pin_o", exp_pin(8'(c), status), pin_o[0])
            `CHK("pin_oe", 1'b1, pin_oe[0])
        end
        apb(1'b1, `ADDR_STAT1, 32'hffff_ffff);
        apb(1'b0, `ADDR_STAT0, 32'(status.eeprom));
        apb(1'b0, `ADDR_STAT1, 32'(status.loops));
        apb(1'b0, `ADDR_STAT2, 32'(status.digital_loop));
        $display("test outputs done");
        apb(1'b1, `ADDR_CFG0, 32'(`OUT_CLKDIV));
        repeat (3) @(posedge pclk);
        w = pin_o[0];
        while (pin_o[0] === w) @(posedge pclk);
        w = pin_o[0];
        n = 0;
        while (pin_o[0] === w) begin
            @(posedge pclk);
            n++;
        end
        `CHK("divider half period", `CLKDIV_RATIO / 2, n)
        $display("test divider done");
        apb(1'b1, `ADDR_CFG1, 32'h0000_0081);
        for (int c = 0; c <= 8'h48; c++) begin
            apb(1'b1, `ADDR_CFG0, 32'(c));
            for (int v = 1; v >= 0; v--) begin
                @(posedge pclk) drv_val[0] <= v[0];
                repeat (4) @(posedge pclk);
                @(negedge pclk);
                `CHK("ctrl", v[0] ? exp_ctrl(8'(c)) : ctrl_t'(0), ctrl)
                `CHK("pin_oe", 1'b0, pin_oe[0])
            end
        end
        $display("test inputs done");
        apb(1'b1, `ADDR_IRQ_MASK, 32'h0);
        apb(1'b1, `ADDR_IRQ_STAT, 32'h0000_0003);
        @(posedge pclk) drv_val[0] <= 1'b1;
        repeat (5) @(posedge pclk);
        @(negedge pclk);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b0, `ADDR_IRQ_STAT, 32'h0000_0001);
        apb(1'b1, `ADDR_IRQ_MASK, 32'h0000_0001);
        @(negedge pclk);
        `CHK("irq", 1'b1, irq)
        apb(1'b1, `ADDR_IRQ_STAT, 32'h0000_0001);
        @(negedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        apb(1'b0, `ADDR_IRQ_STAT, 32'h0);
        apb(1'b0, `ADDR_IRQ_MASK, 32'h0000_0001);
        apb(1'b0, `ADDR_CFG1, 32'h0000_0081);
        // pin 0 driven high by the board, pin 1 reads back its own static high
        apb(1'b0, `ADDR_PIN_STATE, 32'h0000_0003);
        `CHK("pin_o[1]", 1'b1, pin_o[1])
        `CHK("pin_oe[1]", 1'b1, pin_oe[1])
        repeat (3) @(posedge pclk);
        $display("test interrupt done");
        finish_test();
    end
endmodule : tb
bind mfpin_top pin_monitor #(.NPINS(NPINS)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .status(status), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .ctrl(ctrl));
